// [comp_irq_pkg.sv]
/*
  Constants for the comparator interrupt enable mask block: register offsets,
  field positions and reset values. Assumes a plain register port with
  byte addresses and 32-bit data.
*/
//
// Behaviour
// RULE1: Writing one to set register bit 0 enables the startup-done interrupt only.
// RULE2: Writing one to set register bit 1 enables the falling-crossing interrupt.
// RULE3: Writing one to set register bit 2 enables the rising-crossing interrupt.
// RULE4: Writing one to set register bit 3 enables the any-crossing interrupt.
// RULE5: Writing one to clear register bit 0 disables startup-done interrupt only.
// RULE6: Writing one to clear register bit 1 disables the falling-crossing interrupt.
// RULE7: Writing one to clear register bit 2 disables the rising-crossing interrupt.
// RULE8: Set, clear and plain mask registers share one enable state; one means enabled.
// RULE9: Clear bit 3 disables any-crossing; reading set or clear returns the mask.
package comp_irq_pkg;

  localparam logic [11:0] mask_offset  = 12'h300;
  localparam logic [11:0] set_offset   = 12'h304;
  localparam logic [11:0] clear_offset = 12'h308;

  localparam int          event_count  = 4;
  localparam int          ready_bit    = 0;
  localparam int          down_bit     = 1;
  localparam int          up_bit       = 2;
  localparam int          any_threshold_event_bit    = 3;

  localparam logic [3:0]  mask_reset   = 4'h0;
  localparam logic [31:0] read_zero    = 32'h0000_0000;

endpackage : comp_irq_pkg

// [comp_irq_enable.sv]
/*
  Interrupt enable mask for the comparator with write-one-to-set and
  write-one-to-clear access. Assumes the event flags are synchronous to mclk
  and that strobes never arrive together.
*/
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module comp_irq_enable
  import comp_irq_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [3:0]  event_flags,
  output logic [31:0]      rdata,
  output logic [3:0]       irq_enable,
  output logic [3:0]       irq_request
);

  typedef enum logic [1:0] {
    sel_none  = 2'b00,
    sel_mask  = 2'b01,
    sel_set   = 2'b10,
    sel_clear = 2'b11
  } reg_sel_type;

  logic [3:0]  mask_q;
  logic [3:0]  mask_d;
  logic [3:0]  write_bits;
  reg_sel_type reg_sel;
  logic        hit_mask;
  logic        hit_set;
  logic        hit_clear;
  logic        hit_read;

  // One decoder serves both strobes, so a read and a write can never disagree on the map.
  function automatic reg_sel_type decode_sel(input logic [11:0] a);
    reg_sel_type sel;
    sel = sel_none;
    if (a == mask_offset) begin
      sel = sel_mask;
    end else if (a == set_offset) begin
      sel = sel_set;
    end else if (a == clear_offset) begin
      sel = sel_clear;
    end
    return sel;
  endfunction : decode_sel

  function automatic logic [3:0] event_field(input logic [31:0] word);
    return word[event_count-1:0];
  endfunction : event_field

  // Bits above the events read as zero, so software sees no stale upper bits.
  function automatic logic [31:0] read_word(input logic [3:0] mask);
    logic [31:0] word;
    word = read_zero;
    word[event_count-1:0] = mask;
    return word;
  endfunction : read_word

  function automatic logic set_one(input logic old_bit, input logic wr_bit);
    return old_bit | wr_bit;
  endfunction : set_one

  function automatic logic clear_one(input logic old_bit, input logic wr_bit);
    return old_bit & ~wr_bit;
  endfunction : clear_one

  assign reg_sel    = decode_sel(addr);
  assign write_bits = event_field(wdata);
  assign hit_mask   = wr_en && (reg_sel == sel_mask);
  assign hit_set    = wr_en && (reg_sel == sel_set);
  assign hit_clear  = wr_en && (reg_sel == sel_clear);
  assign hit_read   = rd_en && (reg_sel != sel_none);

  // Only ones act, so a set or clear write leaves the other enables untouched; a plain mask write replaces all of them.
  always_comb begin
    mask_d = mask_q;
    if (hit_mask) begin
      mask_d = write_bits; // RULE8
    end
    if (hit_set) begin
      mask_d[ready_bit] = set_one(mask_q[ready_bit], write_bits[ready_bit]); // RULE1
      mask_d[down_bit]  = set_one(mask_q[down_bit], write_bits[down_bit]);   // RULE2
      mask_d[up_bit]    = set_one(mask_q[up_bit], write_bits[up_bit]);       // RULE3
      mask_d[any_threshold_event_bit] = set_one(mask_q[any_threshold_event_bit], write_bits[any_threshold_event_bit]); // RULE4
    end
    if (hit_clear) begin
      mask_d[ready_bit] = clear_one(mask_q[ready_bit], write_bits[ready_bit]); // RULE5
      mask_d[down_bit]  = clear_one(mask_q[down_bit], write_bits[down_bit]);   // RULE6
      mask_d[up_bit]    = clear_one(mask_q[up_bit], write_bits[up_bit]);       // RULE7
      mask_d[any_threshold_event_bit] = clear_one(mask_q[any_threshold_event_bit], write_bits[any_threshold_event_bit]); // RULE9
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_q <= mask_reset;
    end else begin
      mask_q <= mask_d;
    end
  end

  // The output copy takes the next value so it changes at the same edge as the mask.
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_enable <= mask_reset;
    end else begin
      irq_enable <= mask_d;
    end
  end

  // Requests lag the flags by one cycle so the output comes from a flop.
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_request <= mask_reset;
    end else begin
      irq_request <= event_flags & mask_q;
    end
  end

  // Unmapped reads and idle cycles return zero.
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= read_zero;
    end else if (hit_read) begin
      rdata <= read_word(mask_q); // RULE9
    end else begin
      rdata <= read_zero;
    end
  end

  a_set_ready: assert property ( // RULE1
    @(posedge mclk) disable iff (rst)
    hit_set && wdata[ready_bit]
    |=> mask_q[ready_bit]
  ) else $error("set ready failed");

  a_set_keep_ready: assert property ( // RULE1
    @(posedge mclk) disable iff (rst)
    hit_set && !wdata[ready_bit]
    |=> mask_q[ready_bit] == $past(mask_q[ready_bit])
  ) else $error("set keep ready failed");

  a_set_down: assert property ( // RULE2
    @(posedge mclk) disable iff (rst)
    hit_set && wdata[down_bit]
    |=> mask_q[down_bit]
  ) else $error("set down failed");

  a_set_keep_down: assert property ( // RULE2
    @(posedge mclk) disable iff (rst)
    hit_set && !wdata[down_bit]
    |=> mask_q[down_bit] == $past(mask_q[down_bit])
  ) else $error("set keep down failed");

  a_set_up: assert property ( // RULE3
    @(posedge mclk) disable iff (rst)
    hit_set && wdata[up_bit]
    |=> mask_q[up_bit]
  ) else $error("set up failed");

  a_set_keep_up: assert property ( // RULE3
    @(posedge mclk) disable iff (rst)
    hit_set && !wdata[up_bit]
    |=> mask_q[up_bit] == $past(mask_q[up_bit])
  ) else $error("set keep up failed");

  a_set_any_threshold_event: assert property ( // RULE4
    @(posedge mclk) disable iff (rst)
    hit_set
    |=> mask_q == ($past(mask_q) | $past(write_bits))
  ) else $error("set any_threshold_event failed");

  a_set_any: assert property ( // RULE4
    @(posedge mclk) disable iff (rst)
    hit_set && wdata[any_threshold_event_bit]
    |=> mask_q[any_threshold_event_bit]
  ) else $error("set any failed");

  a_set_keep_any: assert property ( // RULE4
    @(posedge mclk) disable iff (rst)
    hit_set && !wdata[any_threshold_event_bit]
    |=> mask_q[any_threshold_event_bit] == $past(mask_q[any_threshold_event_bit])
  ) else $error("set keep any failed");

  a_clear_ready: assert property ( // RULE5
    @(posedge mclk) disable iff (rst)
    hit_clear
    |=> mask_q == ($past(mask_q) & ~$past(write_bits))
  ) else $error("clear keep failed");

  a_clear_startup: assert property ( // RULE5
    @(posedge mclk) disable iff (rst)
    hit_clear && wdata[ready_bit]
    |=> !mask_q[ready_bit]
  ) else $error("clear startup failed");

  a_clear_keep_ready: assert property ( // RULE5
    @(posedge mclk) disable iff (rst)
    hit_clear && !wdata[ready_bit]
    |=> mask_q[ready_bit] == $past(mask_q[ready_bit])
  ) else $error("clear keep ready failed");

  a_clear_down: assert property ( // RULE6
    @(posedge mclk) disable iff (rst)
    hit_clear && wdata[down_bit]
    |=> !mask_q[down_bit]
  ) else $error("clear down failed");

  a_clear_keep_down: assert property ( // RULE6
    @(posedge mclk) disable iff (rst)
    hit_clear && !wdata[down_bit]
    |=> mask_q[down_bit] == $past(mask_q[down_bit])
  ) else $error("clear keep down failed");

  a_clear_up: assert property ( // RULE7
    @(posedge mclk) disable iff (rst)
    hit_clear && wdata[up_bit]
    |=> !mask_q[up_bit]
  ) else $error("clear up failed");

  a_clear_keep_up: assert property ( // RULE7
    @(posedge mclk) disable iff (rst)
    hit_clear && !wdata[up_bit]
    |=> mask_q[up_bit] == $past(mask_q[up_bit])
  ) else $error("clear keep up failed");

  a_clear_any: assert property ( // RULE9
    @(posedge mclk) disable iff (rst)
    hit_clear && wdata[any_threshold_event_bit]
    |=> !mask_q[any_threshold_event_bit]
  ) else $error("clear any failed");

  a_clear_keep_any: assert property ( // RULE9
    @(posedge mclk) disable iff (rst)
    hit_clear && !wdata[any_threshold_event_bit]
    |=> mask_q[any_threshold_event_bit] == $past(mask_q[any_threshold_event_bit])
  ) else $error("clear keep any failed");

  a_mask_write: assert property ( // RULE8
    @(posedge mclk) disable iff (rst)
    hit_mask
    |=> irq_enable == $past(write_bits)
  ) else $error("mask write failed");

  a_idle_hold: assert property ( // RULE8
    @(posedge mclk) disable iff (rst)
    !hit_mask && !hit_set && !hit_clear
    |=> mask_q == $past(mask_q)
  ) else $error("idle hold failed");

  a_read_plain: assert property ( // RULE8
    @(posedge mclk) disable iff (rst)
    rd_en && addr == mask_offset
    |=> rdata == read_word($past(mask_q))
  ) else $error("plain read failed");

  a_read_mask: assert property ( // RULE9
    @(posedge mclk) disable iff (rst)
    rd_en && addr == set_offset
    |=> rdata == read_word($past(mask_q))
  ) else $error("read back failed");

  a_read_clear: assert property ( // RULE9
    @(posedge mclk) disable iff (rst)
    rd_en && addr == clear_offset
    |=> rdata == read_word($past(mask_q))
  ) else $error("clear read failed");

  a_read_idle: assert property (
    @(posedge mclk) disable iff (rst)
    !(rd_en && (addr == mask_offset || addr == set_offset || addr == clear_offset))
    |=> rdata == read_zero
  ) else $error("idle read failed");

  a_request_masked: assert property (
    @(posedge mclk) disable iff (rst)
    1'b1
    |=> (irq_request & ~$past(mask_q)) == 4'h0
  ) else $error("masked request failed");

  a_request_ready: assert property (
    @(posedge mclk) disable iff (rst)
    event_flags[ready_bit] && mask_q[ready_bit]
    |=> irq_request[ready_bit]
  ) else $error("ready request failed");

  a_request_down: assert property (
    @(posedge mclk) disable iff (rst)
    event_flags[down_bit] && mask_q[down_bit]
    |=> irq_request[down_bit]
  ) else $error("down request failed");

  a_request_up: assert property (
    @(posedge mclk) disable iff (rst)
    event_flags[up_bit] && mask_q[up_bit]
    |=> irq_request[up_bit]
  ) else $error("up request failed");

  a_request_any: assert property (
    @(posedge mclk) disable iff (rst)
    event_flags[any_threshold_event_bit] && mask_q[any_threshold_event_bit]
    |=> irq_request[any_threshold_event_bit]
  ) else $error("any request failed");

  a_reset_values: assert property (
    @(posedge mclk)
    rst
    |=> mask_q == mask_reset && irq_enable == mask_reset && irq_request == mask_reset && rdata == read_zero
  ) else $error("reset values failed");

endmodule : comp_irq_enable

// [comp_irq_enable_tb.sv]
/*
  Self-checking bench for the comparator interrupt enable mask.
  Assumes the register port answers a read in the cycle after its strobe.
*/
`timescale 1ns/100ps
module comp_irq_enable_tb;
  import comp_irq_pkg::*;
  logic        mclk = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  event_flags = 4'h0, irq_enable, irq_request;
  int          miscompares = 0, num_checks = 0, cycles = 0;
  comp_irq_enable comp_irq_enable_i(.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .event_flags(event_flags), .rdata(rdata), .irq_enable(irq_enable), .irq_request(irq_request));
  initial forever #4 mclk = ~mclk;
  // The run needs well under a hundred cycles, so a hang is cut short early.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp4(string what, logic [3:0] exp, logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : cmp4
  task automatic wr(logic [11:0] a, logic [31:0] v);
    @(posedge mclk); addr <= a; wdata <= v; wr_en <= 1'b1;
    @(posedge mclk); wr_en <= 1'b0; #1;
  endtask : wr
  task automatic rd(logic [11:0] a);
    @(posedge mclk); addr <= a; rd_en <= 1'b1;
    @(posedge mclk); rd_en <= 1'b0; #1 d = rdata;
  endtask : rd
  task automatic test_set();
    rd(set_offset); cmp("reset", 32'h0, d);
    for (int i = 0; i < 4; i++) begin
      wr(set_offset, 32'hf0 | (32'h1 << i));
      cmp4("set", 4'((32'h1 << (i + 1)) - 1), irq_enable);
    end
    rd(clear_offset); cmp("read clr", 32'hf, d);
    $display("test_set done");
  endtask : test_set
  task automatic test_clear();
    for (int i = 0; i < 4; i++) begin
      wr(clear_offset, 32'h1 << i);
      cmp4("clear", 4'((32'hf << (i + 1)) & 32'hf), irq_enable);
    end
    rd(set_offset); cmp("read set", 32'h0, d);
    $display("test_clear done");
  endtask : test_clear
  task automatic test_mask();
    wr(mask_offset, 32'ha); rd(set_offset); cmp("mask", 32'ha, d);
    rd(mask_offset); cmp("plain read", 32'ha, d);
    @(posedge mclk); #1 cmp("read idle", 32'h0, rdata);
    wr(set_offset, 32'h1); wr(clear_offset, 32'h8); cmp4("shared", 4'h3, irq_enable);
    @(posedge mclk) event_flags <= 4'h6;
    @(posedge mclk); @(posedge mclk); #1 cmp4("request", 4'h2, irq_request);
    @(posedge mclk) event_flags <= 4'hf;
    @(posedge mclk); @(posedge mclk); #1 cmp4("request", 4'h3, irq_request);
    wr(12'h3fc, 32'hf); cmp4("unmapped write", 4'h3, irq_enable);
    rd(12'h3fc); cmp("unmapped", 32'h0, d);
    $display("test_mask done");
  endtask : test_mask
  // Reset in mid-run with all flags high: enables and requests must drop together.
  task automatic test_reset();
    wr(set_offset, 32'hf); cmp4("set all", 4'hf, irq_enable);
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 cmp4("reset enable", 4'h0, irq_enable); cmp4("reset request", 4'h0, irq_request);
    @(posedge mclk) rst <= 1'b0;
    rd(clear_offset); cmp("reset read", 32'h0, d);
    cmp4("request off", 4'h0, irq_request);
    $display("test_reset done");
  endtask : test_reset
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    test_set();
    test_clear();
    test_mask();
    test_reset();
    give_verdict();
  end
endmodule : comp_irq_enable_tb
